// >>> design/wnp_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - at power-up the wiper is forced to midscale, then loaded from nonvolatile store
// - power-on restore into the wiper register lasts a nominal 300 us
// - a restore command reloads the wiper in 300 us; master waits meanwhile
// - a store copies the wiper to nonvolatile store in 26 ms; master waits
// - address select pins are sampled once at power-up and held until repower
// - data is captured on the rising bus clock edge; data line is bidirectional
// - latched select levels form the 7-bit address; only a match is acknowledged
// - store copies wiper to nonvolatile store, restore the reverse; no data byte
// - nonvolatile store holds midscale as its factory content
module wnp_sequencer #(
    parameter int unsigned STORE_CYCLES = wnp_pkg::STORE_CYC,
    parameter int unsigned RESTORE_PWR_CYCLES = wnp_pkg::RESTORE_PWR_CYC,
    parameter int unsigned RESTORE_CMD_CYCLES = wnp_pkg::RESTORE_CMD_CYC,
    parameter int unsigned REWRITE_CYCLES = wnp_pkg::REWRITE_CYC
) (
    // core
    input wire logic i_core_clk,
    input wire logic i_rst,
    // bus link
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    // package address select pins
    input wire logic i_pkg_addr_sel0,
    input wire logic i_pkg_addr_sel1,
    // wiper side
    output logic [7:0] o_wiper,
    output logic [7:0] o_nv_wiper,
    output logic o_busy,
    output logic [6:0] o_dev_addr
);

    // ************************************************************
    // link domain: bits shift in on the bus clock rising edge
    // ************************************************************
    logic [7:0] link_shift;

    always_ff @(posedge i_scl)
    begin
        link_shift <= {link_shift[6:0], i_sda};
    end

    // ************************************************************
    // synchronisers into the core domain
    // ************************************************************
    // the shift word is read only after the synchronised rise, and holds
    // for a whole bus clock period, so the level acts as the qualifier
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] sel0_sync;
    logic [1:0] sel1_sync;
    logic scl_d;
    logic sda_d;

    always_ff @(posedge i_core_clk)
    begin
        scl_sync <= {scl_sync[0], i_scl};
        sda_sync <= {sda_sync[0], i_sda};
        sel0_sync <= {sel0_sync[0], i_pkg_addr_sel0};
        sel1_sync <= {sel1_sync[0], i_pkg_addr_sel1};
        scl_d <= scl_sync[1];
        sda_d <= sda_sync[1];
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = scl_sync[1] && !scl_d;
    assign scl_fall = !scl_sync[1] && scl_d;
    assign bus_start = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    assign bus_stop = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

    // ************************************************************
    // bus decoder
    // ************************************************************
    wnp_pkg::wnp_bus_t bus_state;
    wnp_pkg::wnp_instr_t instr;
    wnp_pkg::wnp_req_t req;
    wnp_pkg::wnp_op_t op_state;
    logic [3:0] bit_cnt;
    logic ack_due;
    logic write_prot;
    logic byte_done;
    assign byte_done = scl_rise && (bit_cnt == (wnp_pkg::BIT_LAST - 4'h1));

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || bus_start || bus_stop)
        begin
            bit_cnt <= 4'h0;
        end
        else if (scl_rise)
        begin
            bit_cnt <= (bit_cnt == wnp_pkg::BIT_LAST) ? 4'h0 : bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        req <= '0;
        if (i_rst)
        begin
            bus_state <= wnp_pkg::BS_IDLE;
            ack_due <= 1'b0;
            instr <= '0;
            write_prot <= 1'b0;
        end
        else if (bus_start)
        begin
            bus_state <= wnp_pkg::BS_ADDR;
            ack_due <= 1'b0;
        end
        else if (bus_stop)
        begin
            bus_state <= wnp_pkg::BS_IDLE;
            ack_due <= 1'b0;
        end
        else if (byte_done)
        begin
            ack_due <= 1'b0;
            case (bus_state)
                wnp_pkg::BS_ADDR:
                begin
                    // only writes are decoded; a busy device stays silent
                    if (link_shift[7:1] == o_dev_addr && !link_shift[0] && !o_busy)
                    begin
                        ack_due <= 1'b1;
                        bus_state <= wnp_pkg::BS_INSTR;
                    end
                    else
                    begin
                        bus_state <= wnp_pkg::BS_SKIP;
                    end
                end
                wnp_pkg::BS_INSTR:
                begin
                    ack_due <= 1'b1;
                    instr <= link_shift;
                    bus_state <= wnp_pkg::BS_DATA;
                    case (link_shift[7:5])
                        wnp_pkg::CMD_STORE:
                        begin
                            req.store <= !write_prot;
                            bus_state <= wnp_pkg::BS_SKIP;
                        end
                        wnp_pkg::CMD_RESTORE:
                        begin
                            req.restore <= 1'b1;
                            bus_state <= wnp_pkg::BS_SKIP;
                        end
                        wnp_pkg::CMD_NOP:
                        begin
                            bus_state <= wnp_pkg::BS_SKIP;
                        end
                        default:
                        begin
                            bus_state <= wnp_pkg::BS_DATA;
                        end
                    endcase
                end
                wnp_pkg::BS_DATA:
                begin
                    ack_due <= 1'b1;
                    bus_state <= wnp_pkg::BS_SKIP;
                    req.data <= link_shift;
                    case (instr.op)
                        wnp_pkg::CMD_WIPER_WR:
                        begin
                            req.wiper_wr <= !write_prot;
                        end
                        wnp_pkg::CMD_NV_WR:
                        begin
                            req.nv_wr <= !write_prot;
                        end
                        wnp_pkg::CMD_WPROT:
                        begin
                            write_prot <= link_shift[0];
                        end
                        default:
                        begin
                            ack_due <= 1'b0;
                        end
                    endcase
                end
                default:
                begin
                    bus_state <= wnp_pkg::BS_SKIP;
                end
            endcase
        end
    end

    // acknowledge: pull low from the fall after bit 8 to the fall after bit 9
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || bus_start || bus_stop)
        begin
            o_sda_oe_n <= 1'b1;
        end
        else if (scl_fall && ack_due && bit_cnt == wnp_pkg::BIT_LAST)
        begin
            o_sda_oe_n <= 1'b0;
        end
        else if (scl_fall && bit_cnt == 4'h0)
        begin
            o_sda_oe_n <= 1'b1;
        end
    end
    assign o_sda = 1'b0;

    // ************************************************************
    // transfer sequencer
    // ************************************************************
    logic [wnp_pkg::CNT_W-1:0] busy_cnt;
    logic [wnp_pkg::CNT_W-1:0] rewrite_cnt;
    logic [7:0] store_src;
    logic rewrite_ok;
    assign rewrite_ok = (rewrite_cnt == '0);
    assign o_busy = (op_state != wnp_pkg::OP_IDLE);

    // nonvolatile writes before the rewrite window has passed are dropped
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            rewrite_cnt <= wnp_pkg::CNT_W'(REWRITE_CYCLES);
        end
        else if (!rewrite_ok)
        begin
            rewrite_cnt <= rewrite_cnt - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            op_state <= wnp_pkg::OP_PRESET;
            busy_cnt <= wnp_pkg::CNT_W'(wnp_pkg::PRESET_CYC);
            o_wiper <= wnp_pkg::WIPER_MID;
            o_nv_wiper <= wnp_pkg::WIPER_MID;
            o_dev_addr <= {wnp_pkg::ADDR_BASE, 2'b00};
            store_src <= 8'h00;
        end
        else
        begin
            case (op_state)
                wnp_pkg::OP_PRESET:
                begin
                    busy_cnt <= busy_cnt - 1'b1;
                    if (busy_cnt == 1)
                    begin
                        // pins caught once; nothing but reset writes this again
                        o_dev_addr <= {wnp_pkg::ADDR_BASE, sel1_sync[1], sel0_sync[1]};
                        op_state <= wnp_pkg::OP_RESTORE;
                        busy_cnt <= wnp_pkg::CNT_W'(RESTORE_PWR_CYCLES);
                    end
                end
                wnp_pkg::OP_RESTORE:
                begin
                    busy_cnt <= busy_cnt - 1'b1;
                    if (busy_cnt == 1)
                    begin
                        o_wiper <= o_nv_wiper;
                        op_state <= wnp_pkg::OP_IDLE;
                    end
                end
                wnp_pkg::OP_STORE:
                begin
                    busy_cnt <= busy_cnt - 1'b1;
                    if (busy_cnt == 1)
                    begin
                        o_nv_wiper <= store_src;
                        op_state <= wnp_pkg::OP_IDLE;
                    end
                end
                wnp_pkg::OP_IDLE:
                begin
                    if (req.restore)
                    begin
                        op_state <= wnp_pkg::OP_RESTORE;
                        busy_cnt <= wnp_pkg::CNT_W'(RESTORE_CMD_CYCLES);
                    end
                    else if ((req.store || req.nv_wr) && rewrite_ok)
                    begin
                        op_state <= wnp_pkg::OP_STORE;
                        busy_cnt <= wnp_pkg::CNT_W'(STORE_CYCLES);
                        store_src <= req.store ? o_wiper : req.data;
                    end
                    else if (req.wiper_wr)
                    begin
                        o_wiper <= req.data;
                    end
                end
                default:
                begin
                    op_state <= wnp_pkg::OP_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [wnp_pkg::CNT_W-1:0] busy_len;
    logic last_store;
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || !o_busy)
        begin
            busy_len <= '0;
        end
        else
        begin
            busy_len <= busy_len + 1'b1;
        end
        if (i_rst || op_state == wnp_pkg::OP_PRESET)
        begin
            last_store <= 1'b0;
        end
        else if (op_state != wnp_pkg::OP_IDLE)
        begin
            last_store <= (op_state == wnp_pkg::OP_STORE);
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    a_preset_mid: assert property ($past(i_rst) |-> o_wiper == 8'h80 && o_busy)
        else $error("wiper not at midscale after reset");
    a_pwr_restore: assert property ($fell(o_busy) && !last_store && $past(busy_len)
        == wnp_pkg::CNT_W'(RESTORE_PWR_CYCLES + wnp_pkg::PRESET_CYC - 1) |-> o_wiper == o_nv_wiper)
        else $error("power-on restore did not load the stored value");
    a_cmd_restore: assert property (op_state == wnp_pkg::OP_IDLE && req.restore
        |=> o_busy [*2] ##0 busy_cnt == wnp_pkg::CNT_W'(RESTORE_CMD_CYCLES - 1))
        else $error("restore command length wrong");
    a_store_len: assert property ($fell(o_busy) && last_store
        |-> $past(busy_len) == wnp_pkg::CNT_W'(STORE_CYCLES - 1))
        else $error("store length wrong");
    a_rewrite_gate: assert property ($changed(o_nv_wiper) |-> $past(rewrite_ok, 2))
        else $error("nonvolatile write before rewrite window");
    a_addr_hold: assert property (op_state != wnp_pkg::OP_PRESET |=> $stable(o_dev_addr))
        else $error("address changed after power-up");
    a_ack_only: assert property (!o_sda_oe_n |-> o_sda == 1'b0 && $past(ack_due))
        else $error("data line driven without an acknowledge");
    a_store_copy: assert property (op_state == wnp_pkg::OP_STORE && busy_cnt == 1
        |=> o_nv_wiper == $past(store_src) && !o_busy)
        else $error("store did not copy the wiper");
    a_factory_mid: assert property ($past(i_rst) |-> o_nv_wiper == 8'h80)
        else $error("stored value not midscale after reset");
    // busy may only drop on the last count of a transfer
    a_busy_match: assert property (o_busy && busy_cnt > 1 |=> o_busy)
        else $error("busy dropped before the transfer ended");

    c_store: cover property (op_state == wnp_pkg::OP_IDLE ##1 op_state == wnp_pkg::OP_STORE);
    c_restore: cover property (req.restore ##1 op_state == wnp_pkg::OP_RESTORE);
    c_ack: cover property ($fell(o_sda_oe_n));
    c_wiper_wr: cover property (req.wiper_wr ##1 $changed(o_wiper));

endmodule : wnp_sequencer

// >>> design/wnp_pkg.sv
package wnp_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned T_STORE_MS = 26;
    localparam int unsigned T_RESTORE_PWR_US = 300;
    localparam int unsigned T_RESTORE_CMD_US = 300;
    localparam int unsigned T_REWRITE_US = 540;
    // longest/nominal times round down to whole cycles, with no one-cycle floor
    localparam int unsigned STORE_CYC = (T_STORE_MS * 1000000) / CLK_PERIOD_PS * 1000;
    localparam int unsigned RESTORE_PWR_CYC = (T_RESTORE_PWR_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned RESTORE_CMD_CYC = (T_RESTORE_CMD_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned REWRITE_CYC = (T_REWRITE_US * 1000000) / CLK_PERIOD_PS;
    // two sync flops plus one to settle before the pins are caught
    localparam int unsigned PRESET_CYC = 3;
    localparam int unsigned CNT_W = 23;

    // ************************************************************
    // values and fields
    // ************************************************************
    localparam logic [7:0] WIPER_MID = 8'h80;
    localparam logic [4:0] ADDR_BASE = 5'h0a;
    localparam logic [3:0] BIT_LAST = 4'h8;

    // instruction byte: command in the top three bits, five zero bits
    typedef struct packed {
        logic [2:0] op;
        logic [4:0] zero;
    } wnp_instr_t;

    localparam logic [2:0] CMD_WIPER_WR = 3'h0;
    localparam logic [2:0] CMD_NV_WR = 3'h1;
    localparam logic [2:0] CMD_WPROT = 3'h2;
    localparam logic [2:0] CMD_NOP = 3'h4;
    localparam logic [2:0] CMD_RESTORE = 3'h5;
    localparam logic [2:0] CMD_STORE = 3'h6;

    // request from the bus decoder to the transfer sequencer
    typedef struct packed {
        logic wiper_wr;
        logic nv_wr;
        logic store;
        logic restore;
        logic [7:0] data;
    } wnp_req_t;

    typedef enum logic [3:0] {
        OP_IDLE = 4'b0001,
        OP_PRESET = 4'b0010,
        OP_RESTORE = 4'b0100,
        OP_STORE = 4'b1000
    } wnp_op_t;

    typedef enum logic [4:0] {
        BS_IDLE = 5'b00001,
        BS_ADDR = 5'b00010,
        BS_INSTR = 5'b00100,
        BS_DATA = 5'b01000,
        BS_SKIP = 5'b10000
    } wnp_bus_t;

endpackage : wnp_pkg

// >>> verification/wnp_i2c_master.sv
`timescale 1ns/1ps
// ************************************************************
// bus master model
// ************************************************************
// edges on a free 15 ns tick unrelated to the core clock; scl idles high
module wnp_i2c_master (
    // link
    input wire logic i_tick,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // low 1.32 us, high 0.63 us: just above the bus minimums
    localparam int LOW_T = 88;
    localparam int HIGH_T = 42;

    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wait_t(input int n);
        repeat (n) @(posedge i_tick);
    endtask : wait_t

    // data moves only while scl is low, after a short hold
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            wait_t(4);
            o_sda = b[i];
            wait_t(LOW_T);
            o_scl = 1'b1;
            wait_t(HIGH_T);
            o_scl = 1'b0;
        end
        wait_t(4);
        o_sda = 1'b1;
        wait_t(LOW_T);
        o_scl = 1'b1;
        wait_t(HIGH_T / 2);
        ack = ~i_sda;
        wait_t(HIGH_T / 2);
        o_scl = 1'b0;
    endtask : send_byte

    // start, n bytes from the top of bytes, stop, then bus free time
    task automatic frame(input logic [23:0] bytes, input int n, output logic [2:0] acks);
        logic a;
        acks = 3'h0;
        o_sda = 1'b0;
        wait_t(HIGH_T);
        o_scl = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            send_byte(bytes[23 - 8 * k -: 8], a);
            acks[2 - k] = a;
        end
        wait_t(4);
        o_sda = 1'b0;
        wait_t(LOW_T);
        o_scl = 1'b1;
        wait_t(HIGH_T);
        o_sda = 1'b1;
        wait_t(LOW_T);
    endtask : frame
endmodule : wnp_i2c_master

// >>> verification/wnp_sequencer_test.sv
`timescale 1ns/1ps
module wnp_sequencer_test;
    // ************************************************************
    // shortened transfer times
    // ************************************************************
    localparam int ST_C = 200;
    localparam int RP_C = 50;
    localparam int RC_C = 40;
    localparam int RW_C = 20000;
    logic i_core_clk;
    logic i_rst;
    logic tick;
    logic sel0;
    logic sel1;
    logic scl;
    logic sda_m;
    logic sda_bus;
    logic dev_sda;
    logic dev_oe_n;
    logic [7:0] wiper;
    logic [7:0] nv;
    logic busy;
    logic [6:0] dev_addr;
    logic [2:0] acks;
    logic [7:0] addr_w;
    int bad_count;
    int comparisons;
    int busy_run;
    int busy_len;

    // open-drain wire with pull-up
    assign sda_bus = sda_m & (dev_oe_n ? 1'b1 : dev_sda);

    wnp_sequencer #(.STORE_CYCLES(ST_C), .RESTORE_PWR_CYCLES(RP_C),
        .RESTORE_CMD_CYCLES(RC_C), .REWRITE_CYCLES(RW_C)) u_wnp_sequencer (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_bus),
        .o_sda(dev_sda), .o_sda_oe_n(dev_oe_n), .i_pkg_addr_sel0(sel0),
        .i_pkg_addr_sel1(sel1), .o_wiper(wiper), .o_nv_wiper(nv), .o_busy(busy),
        .o_dev_addr(dev_addr));

    wnp_i2c_master u_wnp_i2c_master (.i_tick(tick), .i_sda(sda_bus), .o_scl(scl),
        .o_sda(sda_m));

    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    initial
    begin
        tick = 1'b0;
        #3.7;
        forever #7.5 tick = ~tick;
    end

    // length of the last busy run; negedge keeps clear of the launch edge
    always @(negedge i_core_clk)
    begin
        if (i_rst)
            busy_run = 0;
        else if (busy === 1'b1)
            busy_run++;
        else if (busy_run != 0)
        begin
            busy_len = busy_run;
            busy_run = 0;
        end
    end

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_val

    // nominal times allow two cycles either way
    task automatic chk_len(input int got, input int exp, input string what);
        comparisons++;
        if (got < exp - 2 || got > exp + 2)
        begin
            bad_count++;
            $display("FAIL at %0t: %s lasted %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_len

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < lim)
        begin
            @(negedge i_core_clk);
            n++;
        end
        @(negedge i_core_clk);
        chk_val({7'h00, busy}, 8'h00, "busy stuck");
    endtask : wait_idle

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic power_up(input logic s1, input logic s0);
        @(posedge i_core_clk);
        #1;
        i_rst = 1'b1;
        sel1 = s1;
        sel0 = s0;
        repeat (12) @(posedge i_core_clk);
        #1;
        chk_val(wiper, wnp_pkg::WIPER_MID, "preset wiper");
        chk_val({7'h00, busy}, 8'h01, "busy in preset");
        i_rst = 1'b0;
        repeat (wnp_pkg::PRESET_CYC + 4) @(posedge i_core_clk);
        #1;
        sel1 = ~s1;
        sel0 = ~s0;
        wait_idle(RP_C + 20);
        chk_len(busy_len, wnp_pkg::PRESET_CYC + RP_C, "power-on busy");
        chk_val({1'b0, dev_addr}, {1'b0, wnp_pkg::ADDR_BASE, s1, s0}, "address");
        chk_val(wiper, 8'h80, "restored wiper");
        chk_val(nv, 8'h80, "factory store");
        addr_w = {wnp_pkg::ADDR_BASE, s1, s0, 1'b0};
        $display("test power_up done");
    endtask : power_up

    // early store write is acked and dropped; the master would wait instead
    task automatic t_early_nv;
        u_wnp_i2c_master.frame({addr_w, 8'h20, 8'h55}, 3, acks);
        repeat (ST_C + 10) @(posedge i_core_clk);
        #1;
        chk_val(nv, 8'h80, "early store write");
        $display("test early_nv done");
    endtask : t_early_nv

    task automatic t_wiper_write;
        u_wnp_i2c_master.frame({addr_w, 8'h00, 8'h3c}, 3, acks);
        chk_val({5'h00, acks}, 8'h07, "write acks");
        chk_val(wiper, 8'h3c, "wiper written");
        u_wnp_i2c_master.frame({addr_w ^ 8'h02, 8'h00, 8'h99}, 3, acks);
        chk_val({5'h00, acks}, 8'h00, "foreign acks");
        chk_val(wiper, 8'h3c, "wiper kept");
        $display("test wiper_write done");
    endtask : t_wiper_write

    task automatic t_store;
        u_wnp_i2c_master.frame({addr_w, 8'hc0, 8'h00}, 2, acks);
        wait_idle(ST_C + 20);
        chk_val({5'h00, acks}, 8'h06, "store acks");
        chk_len(busy_len, ST_C, "store busy");
        chk_val(nv, 8'h3c, "stored value");
        $display("test store done");
    endtask : t_store

    task automatic t_restore;
        u_wnp_i2c_master.frame({addr_w, 8'h00, 8'h11}, 3, acks);
        chk_val(wiper, 8'h11, "wiper overwritten");
        u_wnp_i2c_master.frame({addr_w, 8'ha0, 8'h00}, 2, acks);
        wait_idle(RC_C + 20);
        chk_len(busy_len, RC_C, "restore busy");
        chk_val(wiper, 8'h3c, "restored value");
        $display("test restore done");
    endtask : t_restore

    task automatic t_late_nv;
        u_wnp_i2c_master.frame({addr_w, 8'h20, 8'h5a}, 3, acks);
        wait_idle(ST_C + 20);
        chk_len(busy_len, ST_C, "store write busy");
        chk_val(nv, 8'h5a, "late store write");
        $display("test late_nv done");
    endtask : t_late_nv

    // protect set: writes are acked yet dropped; the next power-up clears it
    task automatic t_protect;
        u_wnp_i2c_master.frame({addr_w, 8'h40, 8'h01}, 3, acks);
        chk_val({5'h00, acks}, 8'h07, "protect acks");
        u_wnp_i2c_master.frame({addr_w, 8'h00, 8'h77}, 3, acks);
        chk_val({5'h00, acks}, 8'h07, "protected write acks");
        chk_val(wiper, 8'h3c, "protected wiper");
        $display("test protect done");
    endtask : t_protect

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    initial
    begin
        #500000;
        bad_count++;
        $display("FAIL at %0t: watchdog expired", $time);
        summarize();
    end

    initial
    begin
        i_rst = 1'b1;
        sel0 = 1'b0;
        sel1 = 1'b0;
        addr_w = 8'h00;
        bad_count = 0;
        comparisons = 0;
        busy_run = 0;
        busy_len = 0;
        power_up(1'b1, 1'b0);
        t_early_nv();
        t_wiper_write();
        t_store();
        t_restore();
        t_late_nv();
        t_protect();
        power_up(1'b0, 1'b1);
        summarize();
    end
endmodule : wnp_sequencer_test
